//--- port_status_regs.sv
// Notes on behaviour
// - Init-status bit reads 1 until internal startup completes, then 0.
// - Device never sets init flag; host treats first interrupt as startup done.
// - Bus-power monitor enable bit resets to 1 and shows monitoring state.
// - Bus-power present bit reads 1 while VBUS is detected and monitoring is on, else 0.
// - Cable-supply present bit reads 1 when VCONN seen above fixed threshold.
// - Over-voltage fault bit latches on VCONN over-voltage; a read clears it once no such state remains.
// - Over-current flag latches on VCONN over-current; cleared by reading.
// - Over-current flag also latches if VCONN drops while its switch is closed.
// - I2C error flag latches on transmit with empty buffer; read clears it.
// - Code 22h stops bus-power monitoring, 33h restarts it; status bit follows.
// - Code 88h forces the I2C error flag set.
// - Code 99h starts dual-role connection search, only when dual-role enabled.
// - Capability bits 7:5 read 110, all roles supported.
// - Capability bit 4 reads 1, debug packet variants supported.
// - Capability bit 3 reads 1, device can switch VCONN.
// - Capability bits 2:0 read 0, no VBUS power path control.
// - Search status is 1 while looking; falling to 0 marks potential attach.
`timescale 1ns/10ps
`include "port_regs_consts.svh"
module port_status_regs
  import port_regs_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic INIT_DONE,
  input wire logic VBUS_DETECT,
  input wire logic VCONN_DETECT,
  input wire logic VCONN_OV_DETECT,
  input wire logic VCONN_OC_DETECT,
  input wire logic VCONN_SWITCH_ON,
  input wire logic TX_REQUEST,
  input wire logic TX_BUFFER_EMPTY,
  input wire logic DRP_ENABLE,
  input wire logic ATTACH_FOUND,
  output logic BUS_POWER_MONITOR_ON,
  output logic ATTACH_SEARCH_ACTIVE
);

  regs_s st;
  regs_s next_st;
  logic [3:0] pins;
  logic bus_power_seen;
  logic cable_supply_seen;
  logic ov_now;
  logic oc_now;
  logic mon_off;
  logic mon_on;
  logic force_err;
  logic toggle;
  logic rd_fault;
  logic startup_pending_flag;

  localparam regs_s RESET_ST = '{
    mon_on: 1'b1, ov: 1'b0, oc: 1'b0, i2c_err: 1'b0, booted: 1'b0,
    srch: SRCH_IDLE, rdata: 8'h00
  };

  pin_sync u_sync (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .din({VCONN_OC_DETECT, VCONN_OV_DETECT, VCONN_DETECT, VBUS_DETECT}),
    .dout(pins)
  );

  cmd_decode u_cmd (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .wr(REG_WR),
    .addr(REG_ADDR),
    .wdata(REG_WDATA),
    .mon_off(mon_off),
    .mon_on(mon_on),
    .force_err(force_err),
    .toggle(toggle)
  );

  // Monitor powered off hides VBUS presence
  assign bus_power_seen = pins[0] & st.mon_on;
  assign cable_supply_seen = pins[1];
  assign ov_now = pins[2];
  assign oc_now = pins[3];
  assign startup_pending_flag = ~(INIT_DONE | st.booted);
  assign rd_fault = REG_RD && (REG_ADDR == `OFF_FAULT_STATUS);

  function automatic logic [7:0] power_byte(input logic pend, input logic mon,
                                            input logic bus, input logic cab);
    power_byte = 8'h00;
    power_byte[`PS_STARTUP_PENDING] = pend;
    power_byte[`PS_MONITOR_ON] = mon;
    power_byte[`PS_BUS_POWER_SEEN] = bus;
    power_byte[`PS_CABLE_SUPPLY_SEEN] = cab;
  endfunction

  function automatic logic [7:0] fault_byte(input logic ov, input logic oc,
                                            input logic err);
    fault_byte = `FS_RESET;
    fault_byte[`FS_OVERVOLT] = ov;
    fault_byte[`FS_OVERCURRENT] = oc;
    fault_byte[`FS_I2C_ERROR] = err;
  endfunction

  always_comb begin
    next_st = st;
    // Startup flag never comes back once cleared
    next_st.booted = st.booted | INIT_DONE;
    // Monitor enable follows commands
    if (mon_off) begin
      next_st.mon_on = 1'b0;
    end
    if (mon_on) begin
      next_st.mon_on = 1'b1;
    end
    // Over-voltage holds while the fault persists
    if (rd_fault && !ov_now) begin
      next_st.ov = 1'b0;
    end
    if (ov_now) begin
      next_st.ov = 1'b1;
    end
    // Clear on read; a new event wins
    if (rd_fault) begin
      next_st.oc = 1'b0;
      next_st.i2c_err = 1'b0;
    end
    if (oc_now) begin
      next_st.oc = 1'b1;
    end
    if (VCONN_SWITCH_ON && !cable_supply_seen) begin
      next_st.oc = 1'b1;
    end
    if (TX_REQUEST && TX_BUFFER_EMPTY) begin
      next_st.i2c_err = 1'b1;
    end
    if (force_err) begin
      next_st.i2c_err = 1'b1;
    end
    // Connection search
    case (st.srch)
      SRCH_IDLE: begin
        if (toggle && DRP_ENABLE) begin
          next_st.srch = SRCH_RUN;
        end
      end
      SRCH_RUN: begin
        if (ATTACH_FOUND) begin
          next_st.srch = SRCH_HIT;
        end
      end
      SRCH_HIT: begin
        next_st.srch = SRCH_IDLE;
      end
      default: begin
        next_st.srch = SRCH_IDLE;
      end
    endcase
    // Read data, sampled before any clear
    if (REG_RD) begin
      case (REG_ADDR)
        `OFF_POWER_STATUS: begin
          next_st.rdata = power_byte(startup_pending_flag, st.mon_on,
                                     bus_power_seen, cable_supply_seen);
        end
        `OFF_FAULT_STATUS: begin
          next_st.rdata = fault_byte(st.ov, st.oc, st.i2c_err);
        end
        `OFF_COMMAND_CODE: begin
          next_st.rdata = `CMD_RESET;
        end
        `OFF_CAPABILITY_ZERO: begin
          next_st.rdata = {`CAP_ROLES, `CAP_DEBUG_PACKET, `CAP_CABLE_SWITCH,
                           `CAP_PATHS};
        end
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st <= RESET_ST;
    end else begin
      st <= next_st;
    end
  end

  assign REG_RDATA = st.rdata;
  assign BUS_POWER_MONITOR_ON = st.mon_on;
  assign ATTACH_SEARCH_ACTIVE = (st.srch == SRCH_RUN);

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  a_init_status_read: assert property (
    REG_RD && REG_ADDR == `OFF_POWER_STATUS
    |=> REG_RDATA[`PS_STARTUP_PENDING] == !$past(INIT_DONE || st.booted))
    else $error("init status bit wrong");

  a_init_stays_clear: assert property (
    !startup_pending_flag |=> !startup_pending_flag)
    else $error("startup flag raised again");

  a_monitor_bit_read: assert property (
    REG_RD && REG_ADDR == `OFF_POWER_STATUS
    |=> REG_RDATA[`PS_MONITOR_ON] == $past(BUS_POWER_MONITOR_ON))
    else $error("monitor enable bit wrong");

  a_bus_power_bit: assert property (
    REG_RD && REG_ADDR == `OFF_POWER_STATUS
    |=> REG_RDATA[`PS_BUS_POWER_SEEN] == $past(pins[0] && BUS_POWER_MONITOR_ON))
    else $error("bus power bit wrong");

  a_cable_supply_bit: assert property (
    REG_RD && REG_ADDR == `OFF_POWER_STATUS
    |=> REG_RDATA[`PS_CABLE_SUPPLY_SEEN] == $past(pins[1]))
    else $error("cable supply bit wrong");

  a_monitor_off_cmd: assert property (
    REG_WR && REG_ADDR == `OFF_COMMAND_CODE && REG_WDATA == `CMD_MONITOR_OFF
    |=> ##1 !BUS_POWER_MONITOR_ON)
    else $error("monitor not disabled by command");

  a_monitor_on_cmd: assert property (
    REG_WR && REG_ADDR == `OFF_COMMAND_CODE && REG_WDATA == `CMD_MONITOR_ON
    |=> ##1 BUS_POWER_MONITOR_ON)
    else $error("monitor not enabled by command");

  a_monitor_stable: assert property (
    !mon_off && !mon_on |=> $stable(BUS_POWER_MONITOR_ON))
    else $error("monitor changed without command");

  a_force_error: assert property (
    REG_WR && REG_ADDR == `OFF_COMMAND_CODE && REG_WDATA == `CMD_FORCE_ERROR
    |=> ##1 st.i2c_err)
    else $error("forced error flag not set");

  a_tx_error: assert property (
    TX_REQUEST && TX_BUFFER_EMPTY |=> st.i2c_err)
    else $error("empty transmit not flagged");

  a_oc_hold: assert property (
    st.oc && !rd_fault |=> st.oc)
    else $error("over-current flag lost without read");

  a_oc_droop: assert property (
    VCONN_SWITCH_ON && !cable_supply_seen |=> st.oc)
    else $error("supply droop not flagged");

  a_ov_persist: assert property (
    ov_now |=> st.ov)
    else $error("over-voltage not latched");

  a_ov_hold: assert property (
    st.ov && !rd_fault |=> st.ov)
    else $error("over-voltage flag lost without read");

  a_error_read_clear: assert property (
    rd_fault && !(TX_REQUEST && TX_BUFFER_EMPTY) && !force_err |=> !st.i2c_err)
    else $error("error flag not cleared by read");

  a_cmd_reads_zero: assert property (
    REG_RD && REG_ADDR == `OFF_COMMAND_CODE |=> REG_RDATA == 8'h00)
    else $error("command register not zero");

  a_cap_value: assert property (
    REG_RD && REG_ADDR == `OFF_CAPABILITY_ZERO |=> REG_RDATA == `CAP_RESET)
    else $error("capability byte wrong");

  a_cap_debug_bit: assert property (
    REG_RD && REG_ADDR == `OFF_CAPABILITY_ZERO |=> REG_RDATA[4])
    else $error("debug packet capability wrong");

  a_cap_switch_bit: assert property (
    REG_RD && REG_ADDR == `OFF_CAPABILITY_ZERO |=> REG_RDATA[3])
    else $error("cable switch capability wrong");

  a_cap_path_bits: assert property (
    REG_RD && REG_ADDR == `OFF_CAPABILITY_ZERO |=> REG_RDATA[2:0] == 3'h0)
    else $error("power path capability wrong");

  a_search_start: assert property (
    toggle && !DRP_ENABLE && st.srch == SRCH_IDLE |=> !ATTACH_SEARCH_ACTIVE)
    else $error("search started without dual role");

  a_search_begin: assert property (
    toggle && DRP_ENABLE && st.srch == SRCH_IDLE |=> ATTACH_SEARCH_ACTIVE)
    else $error("search not started by command");

  a_search_hold: assert property (
    ATTACH_SEARCH_ACTIVE && !ATTACH_FOUND |=> ATTACH_SEARCH_ACTIVE)
    else $error("search ended without attach");

  a_search_hit: assert property (
    ATTACH_SEARCH_ACTIVE && ATTACH_FOUND |=> !ATTACH_SEARCH_ACTIVE ##1 st.srch == SRCH_IDLE)
    else $error("search did not end on attach");

  c_toggle_run: cover property (toggle && DRP_ENABLE ##1 ATTACH_SEARCH_ACTIVE);
  c_error_read: cover property (st.i2c_err && rd_fault ##1 !st.i2c_err);
  c_monitor_cycle: cover property (mon_off ##[1:20] mon_on);
  c_oc_latch: cover property (oc_now ##1 st.oc);
  c_startup_done: cover property (startup_pending_flag ##1 !startup_pending_flag);

endmodule // port_status_regs

//--- port_regs_consts.svh
`ifndef PORT_REGS_CONSTS_SVH
`define PORT_REGS_CONSTS_SVH

// Register offsets
`define OFF_POWER_STATUS 8'h1e
`define OFF_FAULT_STATUS 8'h1f
`define OFF_COMMAND_CODE 8'h23
`define OFF_CAPABILITY_ZERO 8'h24

// Power status fields
`define PS_STARTUP_PENDING 6
`define PS_MONITOR_ON 3
`define PS_BUS_POWER_SEEN 2
`define PS_CABLE_SUPPLY_SEEN 1
`define PS_RESET 8'h08

// Fault status fields
`define FS_OVERVOLT 7
`define FS_OVERCURRENT 1
`define FS_I2C_ERROR 0
`define FS_RESET 8'h00

// Command codes
`define CMD_MONITOR_OFF 8'h22
`define CMD_MONITOR_ON 8'h33
`define CMD_FORCE_ERROR 8'h88
`define CMD_START_TOGGLE 8'h99
`define CMD_RESET 8'h00

// Capability byte: roles 110, debug 1, cable switch 1, paths 000
`define CAP_ROLES 3'h6
`define CAP_DEBUG_PACKET 1'h1
`define CAP_CABLE_SWITCH 1'h1
`define CAP_PATHS 3'h0
`define CAP_RESET 8'hd8

`endif

//--- port_regs_pkg.sv
package port_regs_pkg;

  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_MON_OFF = 3'h1,
    CMD_MON_ON = 3'h2,
    CMD_FORCE_ERR = 3'h3,
    CMD_TOGGLE = 3'h4
  } cmd_e;

  typedef enum logic [1:0] {
    SRCH_IDLE = 2'h0,
    SRCH_RUN = 2'h1,
    SRCH_HIT = 2'h3
  } srch_e;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] level;
  } sync_s;

  typedef struct packed {
    logic mon_off;
    logic mon_on;
    logic force_err;
    logic toggle;
  } cmd_s;

  typedef struct packed {
    logic mon_on;
    logic ov;
    logic oc;
    logic i2c_err;
    logic booted;
    srch_e srch;
    logic [7:0] rdata;
  } regs_s;

endpackage

//--- pin_sync.sv
`timescale 1ns/10ps
module pin_sync
  import port_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] din,
  output logic [3:0] dout
);

  sync_s st;
  sync_s next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // Accept a change once stages two and three agree
    for (int i = 0; i < 4; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.level[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.level;

endmodule // pin_sync

//--- cmd_decode.sv
`timescale 1ns/10ps
`include "port_regs_consts.svh"
module cmd_decode
  import port_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic mon_off,
  output logic mon_on,
  output logic force_err,
  output logic toggle
);

  function automatic cmd_e decode_cmd(input logic [7:0] code);
    case (code)
      `CMD_MONITOR_OFF: decode_cmd = CMD_MON_OFF;
      `CMD_MONITOR_ON: decode_cmd = CMD_MON_ON;
      `CMD_FORCE_ERROR: decode_cmd = CMD_FORCE_ERR;
      `CMD_START_TOGGLE: decode_cmd = CMD_TOGGLE;
      default: decode_cmd = CMD_NONE;
    endcase
  endfunction

  cmd_s st;
  cmd_s next_st;
  cmd_e code;

  always_comb begin
    code = CMD_NONE;
    if (wr && addr == `OFF_COMMAND_CODE) begin
      code = decode_cmd(wdata);
    end
    // Unknown codes leave every pulse low
    next_st.mon_off = (code == CMD_MON_OFF);
    next_st.mon_on = (code == CMD_MON_ON);
    next_st.force_err = (code == CMD_FORCE_ERR);
    next_st.toggle = (code == CMD_TOGGLE);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign mon_off = st.mon_off;
  assign mon_on = st.mon_on;
  assign force_err = st.force_err;
  assign toggle = st.toggle;

endmodule // cmd_decode

//--- port_far_model.sv
`timescale 1ns/10ps
module port_far_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic search_on,
  input wire logic [7:0] delay,
  output logic attach_found
);
  logic [7:0] cnt;
  // Hit after a chosen number of search cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 8'h00;
      attach_found <= 1'b0;
    end else begin
      attach_found <= search_on && cnt == delay;
      cnt <= search_on ? cnt + 8'h01 : 8'h00;
    end
  end
endmodule // port_far_model

//--- port_status_regs_tb_top.sv
`timescale 1ns/10ps
`include "port_regs_consts.svh"
module port_status_regs_tb_top;
  import port_regs_pkg::*;
  logic SYS_CLK, RESET_N, REG_WR, REG_RD, INIT_DONE, VBUS_DETECT, VCONN_DETECT;
  logic VCONN_OV_DETECT, VCONN_OC_DETECT, VCONN_SWITCH_ON, TX_REQUEST;
  logic TX_BUFFER_EMPTY, DRP_ENABLE, ATTACH_FOUND, rd_d;
  logic BUS_POWER_MONITOR_ON, ATTACH_SEARCH_ACTIVE;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, hit_delay, code;
  logic [7:0] exp_q[$];
  int n_mismatch, compares, cycles;

  port_status_regs i_port_status_regs (.SYS_CLK, .RESET_N, .REG_ADDR, .REG_WR,
    .REG_WDATA, .REG_RD, .REG_RDATA, .INIT_DONE, .VBUS_DETECT, .VCONN_DETECT,
    .VCONN_OV_DETECT, .VCONN_OC_DETECT, .VCONN_SWITCH_ON, .TX_REQUEST,
    .TX_BUFFER_EMPTY, .DRP_ENABLE, .ATTACH_FOUND, .BUS_POWER_MONITOR_ON,
    .ATTACH_SEARCH_ACTIVE);
  port_far_model i_port_far_model (.clk(SYS_CLK), .rst_n(RESET_N),
    .search_on(ATTACH_SEARCH_ACTIVE), .delay(hit_delay), .attach_found(ATTACH_FOUND));

  initial begin
    SYS_CLK = 1'b0;
    forever #25 SYS_CLK = ~SYS_CLK;
  end

  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cmp8(logic [7:0] got, logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk(logic got, logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic step(int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    step(1);
    REG_WR = 1'b0;
    step(2);
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    REG_ADDR = a;
    REG_RD = 1'b1;
    step(1);
    REG_RD = 1'b0;
    step(1);
  endtask

  // Read data checker and hang guard
  always @(posedge SYS_CLK) begin
    if (rd_d && exp_q.size() > 0) begin
      cmp8(REG_RDATA, exp_q.pop_front());
    end
    rd_d <= REG_RD === 1'b1;
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    {REG_WR, REG_RD, INIT_DONE, VBUS_DETECT, VCONN_DETECT, VCONN_OV_DETECT} = '0;
    {VCONN_OC_DETECT, VCONN_SWITCH_ON, TX_REQUEST, TX_BUFFER_EMPTY, DRP_ENABLE} = '0;
    {REG_ADDR, REG_WDATA, code} = '0;
    hit_delay = 8'h03;
    RESET_N = 1'b0;
    void'($urandom(14));
    step(16);
    RESET_N = 1'b1;
    chk(BUS_POWER_MONITOR_ON, 1'b1);
    rd(`OFF_POWER_STATUS, 8'h48);
    INIT_DONE = 1'b1;
    step(1);
    rd(`OFF_POWER_STATUS, 8'h08);
    INIT_DONE = 1'b0;
    rd(`OFF_POWER_STATUS, 8'h08);
    INIT_DONE = 1'b1;
    rd(`OFF_FAULT_STATUS, 8'h00);
    wr(`OFF_CAPABILITY_ZERO, 8'h00);
    rd(`OFF_CAPABILITY_ZERO, {3'b110, 1'b1, 1'b1, 3'b000});
    rd(8'h30, 8'h00);
    VBUS_DETECT = 1'b1;
    VCONN_DETECT = 1'b1;
    step(8);
    rd(`OFF_POWER_STATUS, 8'h0e);
    wr(`OFF_COMMAND_CODE, `CMD_MONITOR_OFF);
    chk(BUS_POWER_MONITOR_ON, 1'b0);
    rd(`OFF_POWER_STATUS, 8'h02);
    wr(`OFF_COMMAND_CODE, `CMD_MONITOR_ON);
    chk(BUS_POWER_MONITOR_ON, 1'b1);
    rd(`OFF_COMMAND_CODE, 8'h00);
    // Random codes outside the command set
    for (int i = 0; i < 8; i++) begin
      code = 8'($urandom);
      if (code inside {8'h22, 8'h33, 8'h88, 8'h99}) begin
        code = 8'h11;
      end
      wr(`OFF_COMMAND_CODE, code);
    end
    rd(`OFF_POWER_STATUS, 8'h0e);
    rd(`OFF_FAULT_STATUS, 8'h00);
    chk(ATTACH_SEARCH_ACTIVE, 1'b0);
    wr(`OFF_COMMAND_CODE, `CMD_FORCE_ERROR);
    rd(`OFF_FAULT_STATUS, 8'h01);
    rd(`OFF_FAULT_STATUS, 8'h00);
    for (int e = 0; e < 2; e++) begin
      TX_BUFFER_EMPTY = e[0];
      TX_REQUEST = 1'b1;
      step(1);
      TX_REQUEST = 1'b0;
      step(1);
      rd(`OFF_FAULT_STATUS, {7'h00, e[0]});
    end
    rd(`OFF_FAULT_STATUS, 8'h00);
    VCONN_OC_DETECT = 1'b1;
    step(4);
    VCONN_OC_DETECT = 1'b0;
    step(8);
    rd(`OFF_FAULT_STATUS, 8'h02);
    rd(`OFF_FAULT_STATUS, 8'h00);
    VCONN_SWITCH_ON = 1'b1;
    step(3);
    rd(`OFF_FAULT_STATUS, 8'h00);
    VCONN_DETECT = 1'b0;
    step(8);
    rd(`OFF_FAULT_STATUS, 8'h02);
    VCONN_SWITCH_ON = 1'b0;
    step(2);
    rd(`OFF_FAULT_STATUS, 8'h02);
    rd(`OFF_FAULT_STATUS, 8'h00);
    rd(`OFF_POWER_STATUS, 8'h0c);
    VCONN_OV_DETECT = 1'b1;
    step(8);
    rd(`OFF_FAULT_STATUS, 8'h80);
    rd(`OFF_FAULT_STATUS, 8'h80);
    VCONN_OV_DETECT = 1'b0;
    step(8);
    rd(`OFF_FAULT_STATUS, 8'h80);
    rd(`OFF_FAULT_STATUS, 8'h00);
    wr(`OFF_COMMAND_CODE, `CMD_START_TOGGLE);
    chk(ATTACH_SEARCH_ACTIVE, 1'b0);
    DRP_ENABLE = 1'b1;
    // Prompt and slow far side
    for (int j = 0; j < 2; j++) begin
      hit_delay = j == 0 ? 8'h03 : 8'h3c;
      wr(`OFF_COMMAND_CODE, `CMD_START_TOGGLE);
      chk(ATTACH_SEARCH_ACTIVE, 1'b1);
      for (int k = 0; k < 100 && ATTACH_SEARCH_ACTIVE === 1'b1; k++) begin
        step(1);
      end
      chk(ATTACH_SEARCH_ACTIVE, 1'b0);
      step(2);
    end
    wr(`OFF_COMMAND_CODE, `CMD_MONITOR_OFF);
    RESET_N = 1'b0;
    step(2);
    RESET_N = 1'b1;
    chk(BUS_POWER_MONITOR_ON, 1'b1);
    step(3);
    close_out();
  end
endmodule // port_status_regs_tb_top
